// ===== core/rbt_pkg.sv
// constants and types shared by the bus transceiver core, its far side model and its bench
// assumes a single 100 MHz clock domain and a classic wishbone master
package rbt_pkg;

	// data path
	localparam int unsigned DATA_W = 18;
	localparam int unsigned LOG_DEPTH = 8;
	localparam int unsigned CNT_W = $clog2(LOG_DEPTH + 1);

	// wishbone word offsets, byte addresses
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_LOG = 8'h08;
	localparam logic [7:0] OFS_FWD_HELD = 8'h0C;
	localparam logic [7:0] OFS_REV_HELD = 8'h10;

	// field positions
	localparam int unsigned CTRL_LOG_EN = 0;
	localparam int unsigned ST_FWD_DRV = 0;
	localparam int unsigned ST_REV_DRV = 1;
	localparam int unsigned ST_LOG_VALID = 2;
	localparam int unsigned ST_LOG_FULL = 3;
	localparam int unsigned ST_LOG_CNT = 8;

	// reset values
	localparam logic CTRL_RESET = 1'b0;
	localparam logic [DATA_W-1:0] PATH_RESET = 18'h0_0000;
	localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

	// control pins of one direction
	typedef struct packed {
		logic drive_en_n;
		logic clk_en_n;
		logic latch_open;
		logic capture_clk;
	} dir_ctrl_type;

	// latch then flip-flop of one direction
	typedef struct packed {
		logic [DATA_W-1:0] latch;
		logic [DATA_W-1:0] flop;
	} path_type;

endpackage

// ===== core/rbt_fifo.sv
// flop based fifo with valid and ready on both sides
// assumes one clock and a synchronous active high reset
module rbt_fifo #(
	parameter int unsigned WIDTH = 18,
	parameter int unsigned DEPTH = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	// fill level
	output logic [$clog2(DEPTH+1)-1:0] count_o
);

	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	logic push;
	logic pop;

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	assign in_ready_o = (cnt_q != CW'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem_q[rd_q];
	assign count_o = cnt_q;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= ptr_inc(wr_q);
			end
			if (pop) begin
				rd_q <= ptr_inc(rd_q);
			end
			cnt_q <= CW'(cnt_q + CW'(push) - CW'(pop));
		end
	end

endmodule // rbt_fifo

// ===== core/rbt_core.sv
// 18 bit registered bus transceiver, both directions, with capture log
// assumes pins arrive asynchronously and a classic wishbone master
//
// Functional notes
// RQ1: eighteen independent bits each way, one latch and one flop per bit.
// RQ2: each bit passes a transparent latch then an edge triggered flop.
// RQ3: forward drive enable high releases every backplane line.
// RQ4: forward latch open makes backplane follow card lines, clock ignored.
// RQ5: latch closed, clock enabled: rising capture clock loads card lines; here no load while logging is on and the log is full.
// RQ6: latch closed, clock enable high: outputs hold, clock edges ignored.
// RQ7: static clock holds output; high clock needs latch closed while high.
// RQ8: reverse direction works the same with its own four controls.
// RQ9: backplane side only pulls low or releases, never drives high.
// RQ10: card lines drive reverse data only while reverse enable is low.
// RQ11: the system keeps every unused input at a defined level.
// RQ12: contents undefined at start; drive stays released after reset.
//
// Local design decisions: register access over Wishbone and the register offsets.
module rbt_core (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// forward controls, card to backplane
	input wire logic fwd_drive_en_n_i,
	input wire logic fwd_clk_en_n_i,
	input wire logic fwd_latch_open_i,
	input wire logic fwd_capture_clk_i,
	// reverse controls, backplane to card
	input wire logic rev_drive_en_n_i,
	input wire logic rev_clk_en_n_i,
	input wire logic rev_latch_open_i,
	input wire logic rev_capture_clk_i,
	// card side three state lines
	input wire logic [rbt_pkg::DATA_W-1:0] card_side_lines_i,
	output logic [rbt_pkg::DATA_W-1:0] card_side_lines_o,
	output logic [rbt_pkg::DATA_W-1:0] card_side_lines_oe_o,
	// backplane open drain lines
	input wire logic [rbt_pkg::DATA_W-1:0] backplane_lines_i,
	output logic [rbt_pkg::DATA_W-1:0] backplane_lines_o,
	output logic [rbt_pkg::DATA_W-1:0] backplane_lines_oe_o,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	localparam int unsigned DW = rbt_pkg::DATA_W;
	localparam int unsigned CW = rbt_pkg::CNT_W;
	localparam int unsigned SYNC_W = 2 * DW + 8;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [SYNC_W-1:0] pins;
	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	rbt_pkg::dir_ctrl_type fwd_c;
	rbt_pkg::dir_ctrl_type rev_c;
	logic [DW-1:0] card_s;
	logic [DW-1:0] bp_s;
	logic fwd_clk_prev_q;
	logic rev_clk_prev_q;

	assign pins = {fwd_drive_en_n_i, fwd_clk_en_n_i, fwd_latch_open_i,
		fwd_capture_clk_i, rev_drive_en_n_i, rev_clk_en_n_i,
		rev_latch_open_i, rev_capture_clk_i, card_side_lines_i,
		backplane_lines_i};

	// floating pins cannot be cleaned up here, only synchronised
	always_ff @(posedge clk_i) begin
		sync1_q <= pins; // RQ11
		sync2_q <= sync1_q;
	end

	assign fwd_c = sync2_q[SYNC_W-1 -: 4];
	assign rev_c = sync2_q[SYNC_W-5 -: 4];
	assign card_s = sync2_q[2*DW-1 -: DW];
	assign bp_s = sync2_q[DW-1:0];

	// previous clock level, for edge detection after the synchroniser;
	// no reset: a clock already high at reset release is no edge
	always_ff @(posedge clk_i) begin
		fwd_clk_prev_q <= fwd_c.capture_clk; // RQ7
		rev_clk_prev_q <= rev_c.capture_clk;
	end

	////////////////////////////////////////////////////////////////////////
	// latch and flop of one direction

	function automatic logic is_rise(input rbt_pkg::dir_ctrl_type c,
		input logic prev);
		is_rise = c.capture_clk && !prev;
	endfunction

	// latch open while latch_open is high, or while the clock sat low
	// with the clock enabled; a clock already high keeps it closed
	function automatic rbt_pkg::path_type path_next(
		input rbt_pkg::dir_ctrl_type c,
		input logic prev,
		input logic [DW-1:0] din,
		input rbt_pkg::path_type cur,
		input logic stall);
		rbt_pkg::path_type nx;
		nx = cur;
		if (c.latch_open || (!prev && !c.clk_en_n)) begin
			nx.latch = din; // RQ2
		end
		if (c.latch_open) begin
			nx.flop = nx.latch; // RQ4
		end else if (is_rise(c, prev) && !c.clk_en_n && !stall) begin
			nx.flop = nx.latch; // RQ5
		end
		path_next = nx;
	endfunction

	rbt_pkg::path_type fwd_q;
	rbt_pkg::path_type fwd_d;
	rbt_pkg::path_type rev_q;
	rbt_pkg::path_type rev_d;
	logic fwd_stall;
	logic log_push;
	logic log_ready;

	assign fwd_d = path_next(fwd_c, fwd_clk_prev_q, card_s, fwd_q,
		fwd_stall); // RQ1
	assign rev_d = path_next(rev_c, rev_clk_prev_q, bp_s, rev_q,
		1'b0); // RQ8

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fwd_q <= {rbt_pkg::PATH_RESET, rbt_pkg::PATH_RESET};
			rev_q <= {rbt_pkg::PATH_RESET, rbt_pkg::PATH_RESET};
		end else begin
			fwd_q <= fwd_d;
			rev_q <= rev_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drivers

	logic [DW-1:0] bp_oe_q;
	logic [DW-1:0] card_o_q;
	logic [DW-1:0] card_oe_q;

	// released from reset until a drive enable pin goes low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bp_oe_q <= '0; // RQ12
			card_o_q <= '0;
			card_oe_q <= '0;
		end else begin
			bp_oe_q <= fwd_c.drive_en_n ? '0 : ~fwd_d.flop; // RQ3 RQ9
			card_o_q <= rev_d.flop; // RQ8
			card_oe_q <= rev_c.drive_en_n ? '0 : '1; // RQ10
		end
	end

	assign backplane_lines_o = '0; // RQ9
	assign backplane_lines_oe_o = bp_oe_q;
	assign card_side_lines_o = card_o_q;
	assign card_side_lines_oe_o = card_oe_q;

	////////////////////////////////////////////////////////////////////////
	// capture log fifo

	logic log_en_q;
	logic log_valid;
	logic log_pop;
	logic [DW-1:0] log_data;
	logic [CW-1:0] log_cnt;

	// a full log stalls forward captures instead of dropping words
	assign log_push = log_en_q && !fwd_c.latch_open && !fwd_c.clk_en_n
		&& is_rise(fwd_c, fwd_clk_prev_q);
	assign fwd_stall = log_push && !log_ready;

	rbt_fifo #(
		.WIDTH(DW),
		.DEPTH(rbt_pkg::LOG_DEPTH)
	) u_log (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(log_push),
		.in_ready_o(log_ready),
		.in_data_i(card_s),
		.out_valid_o(log_valid),
		.out_ready_i(log_pop),
		.out_data_o(log_data),
		.count_o(log_cnt)
	);

	////////////////////////////////////////////////////////////////////////
	// wishbone slave, answers one cycle after the request

	logic ack_q;
	logic [31:0] dat_q;
	logic req_new;
	logic [31:0] rd_val;

	assign req_new = wb_cyc_i && wb_stb_i && !ack_q;
	assign log_pop = req_new && !wb_we_i && (wb_adr_i == rbt_pkg::OFS_LOG);

	always_comb begin
		rd_val = rbt_pkg::BUS_ZERO;
		unique case (wb_adr_i)
			rbt_pkg::OFS_CTRL: rd_val[rbt_pkg::CTRL_LOG_EN] = log_en_q;
			rbt_pkg::OFS_STATUS: begin
				rd_val[rbt_pkg::ST_FWD_DRV] = !fwd_c.drive_en_n;
				rd_val[rbt_pkg::ST_REV_DRV] = !rev_c.drive_en_n;
				rd_val[rbt_pkg::ST_LOG_VALID] = log_valid;
				rd_val[rbt_pkg::ST_LOG_FULL] = !log_ready;
				rd_val[rbt_pkg::ST_LOG_CNT +: CW] = log_cnt;
			end
			rbt_pkg::OFS_LOG: rd_val[DW-1:0] = log_valid ? log_data : '0;
			rbt_pkg::OFS_FWD_HELD: rd_val[DW-1:0] = fwd_q.flop;
			rbt_pkg::OFS_REV_HELD: rd_val[DW-1:0] = rev_q.flop;
			default: rd_val = rbt_pkg::BUS_ZERO;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= rbt_pkg::BUS_ZERO;
		end else begin
			ack_q <= req_new;
			if (req_new && !wb_we_i) begin
				dat_q <= rd_val;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			log_en_q <= rbt_pkg::CTRL_RESET;
		end else if (req_new && wb_we_i && wb_sel_i[0]
			&& wb_adr_i == rbt_pkg::OFS_CTRL) begin
			log_en_q <= wb_dat_i[rbt_pkg::CTRL_LOG_EN];
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_wb_req;
		wb_cyc_i && wb_stb_i && !ack_q;
	endsequence

	sequence s_fwd_capture;
		!fwd_c.latch_open && !fwd_c.clk_en_n
			&& is_rise(fwd_c, fwd_clk_prev_q) && !fwd_stall;
	endsequence

	a_bus_ack_once: assert property ( // RQ12
		s_wb_req |=> ack_q ##1 !ack_q)
		else $error("bus ack not a single cycle pulse");

	a_fwd_release: assert property ( // RQ3
		fwd_c.drive_en_n |=> bp_oe_q == '0)
		else $error("backplane driven while forward disabled");

	a_fwd_follow_card: assert property ( // RQ4
		!fwd_c.drive_en_n && fwd_c.latch_open
			|=> bp_oe_q == ~$past(card_s))
		else $error("backplane does not follow card in transparent mode");

	a_fwd_clock_load: assert property ( // RQ5
		s_fwd_capture |=> fwd_q.flop == $past(card_s))
		else $error("forward capture did not load card lines");

	a_fwd_inhibit_hold: assert property ( // RQ6
		!fwd_c.latch_open && fwd_c.clk_en_n |=> $stable(fwd_q.flop))
		else $error("forward flop moved under clock inhibit");

	a_fwd_static_hold: assert property ( // RQ7
		!fwd_c.latch_open && !is_rise(fwd_c, fwd_clk_prev_q)
			|=> $stable(fwd_q.flop))
		else $error("forward flop moved without a clock edge");

	a_latch_closed_hold: assert property ( // RQ2
		!fwd_c.latch_open && fwd_clk_prev_q |=> $stable(fwd_q.latch))
		else $error("forward latch moved while closed");

	a_rev_card_drive: assert property ( // RQ10
		!rev_c.drive_en_n |=> card_oe_q == '1 ##0 card_o_q == rev_q.flop)
		else $error("card lines not driven with reverse data");

	a_rev_release: assert property ( // RQ10
		rev_c.drive_en_n |=> card_oe_q == '0)
		else $error("card lines driven while reverse disabled");

	a_rev_follow_bp: assert property ( // RQ8
		rev_c.latch_open |=> card_o_q == $past(bp_s))
		else $error("card output does not follow backplane");

	a_bp_never_high: assert property ( // RQ9
		!fwd_c.drive_en_n |=> (bp_oe_q == ~fwd_q.flop)
			&& (backplane_lines_o == '0))
		else $error("backplane pulled where stored bit is high");

	a_full_log_stall: assert property ( // RQ5
		log_push && !log_ready && !fwd_c.latch_open
			|=> $stable(fwd_q.flop))
		else $error("capture taken while log full");

	sequence s_rev_capture;
		!rev_c.latch_open && !rev_c.clk_en_n
			&& is_rise(rev_c, rev_clk_prev_q);
	endsequence

	a_rev_clock_load: assert property ( // RQ8
		s_rev_capture |=> rev_q.flop == $past(bp_s))
		else $error("reverse capture did not load backplane lines");

	a_rev_inhibit_hold: assert property ( // RQ6
		!rev_c.latch_open && rev_c.clk_en_n |=> $stable(rev_q.flop))
		else $error("reverse flop moved under clock inhibit");

	a_rev_static_hold: assert property ( // RQ7
		!rev_c.latch_open && !is_rise(rev_c, rev_clk_prev_q)
			|=> $stable(rev_q.flop))
		else $error("reverse flop moved without a clock edge");

	a_rev_latch_hold: assert property ( // RQ2
		!rev_c.latch_open && rev_clk_prev_q |=> $stable(rev_q.latch))
		else $error("reverse latch moved while closed");

	a_ack_needs_req: assert property ( // RQ12
		!(wb_cyc_i && wb_stb_i) |=> !ack_q)
		else $error("bus ack without a request");

	a_log_never_over: assert property ( // RQ5
		log_cnt <= CW'(rbt_pkg::LOG_DEPTH))
		else $error("capture log count beyond its depth");

endmodule // rbt_core

// ===== sim/rbt_far_side.sv
// far side: shared backplane wire with pull-up, and card logic
// assumes a set oe bit means the core pulls that backplane bit low
module rbt_far_side (
	// core outputs
	input wire logic [rbt_pkg::DATA_W-1:0] bp_oe_i,
	input wire logic [rbt_pkg::DATA_W-1:0] card_o_i,
	input wire logic [rbt_pkg::DATA_W-1:0] card_oe_i,
	// what the far parties drive
	input wire logic [rbt_pkg::DATA_W-1:0] bp_data_i,
	input wire logic [rbt_pkg::DATA_W-1:0] card_data_i,
	// resolved wires
	output logic [rbt_pkg::DATA_W-1:0] bp_wire_o,
	output logic [rbt_pkg::DATA_W-1:0] card_wire_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// wired-and: any puller wins, pull-up otherwise
	assign bp_wire_o = ~bp_oe_i & bp_data_i;
	// card logic yields, never floats the pins
	assign card_wire_o = card_oe_i & card_o_i | ~card_oe_i & card_data_i;
endmodule // rbt_far_side

// ===== sim/registered_bus_transceiver_test.sv
// bench for the transceiver core: pin modes, registers, capture log
// assumes the far side model resolves both sets of pins
module registered_bus_transceiver_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0;
	logic rst_i = 1;
	rbt_pkg::dir_ctrl_type fwd = 4'b1100;
	rbt_pkg::dir_ctrl_type rev = 4'b1100;
	logic [17:0] card_d = 18'h0_0000;
	logic [17:0] bp_d = 18'h3_FFFF;
	logic [17:0] card_o, card_oe, bp_o, bp_oe, bp_w, card_w;
	logic cyc = 0;
	logic stb = 0;
	logic we = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat, q;
	logic ack;
	int errors = 0;
	int checked = 0;

	always #5 clk_i = ~clk_i;

	rbt_core uut (.clk_i(clk_i), .rst_i(rst_i),
		.fwd_drive_en_n_i(fwd.drive_en_n), .fwd_clk_en_n_i(fwd.clk_en_n),
		.fwd_latch_open_i(fwd.latch_open),
		.fwd_capture_clk_i(fwd.capture_clk),
		.rev_drive_en_n_i(rev.drive_en_n), .rev_clk_en_n_i(rev.clk_en_n),
		.rev_latch_open_i(rev.latch_open),
		.rev_capture_clk_i(rev.capture_clk),
		.card_side_lines_i(card_w), .card_side_lines_o(card_o),
		.card_side_lines_oe_o(card_oe), .backplane_lines_i(bp_w),
		.backplane_lines_o(bp_o), .backplane_lines_oe_o(bp_oe),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

	rbt_far_side far (.bp_oe_i(bp_oe), .card_o_i(card_o),
		.card_oe_i(card_oe), .bp_data_i(bp_d), .card_data_i(card_d),
		.bp_wire_o(bp_w), .card_wire_o(card_w));

	////////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one classic cycle; request held until ack is seen at an edge,
	// only the watchdog ends a wait that never gets its ack
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 0;
		stb <= 0;
		@(posedge clk_i);
	endtask

	// pins pass a synchroniser, so give them time to land
	task automatic settle;
		repeat (5) @(posedge clk_i);
	endtask

	// clock held low then high for four cycles each
	task automatic cap(input logic [17:0] d);
		card_d <= d;
		fwd.capture_clk <= 0;
		repeat (4) @(posedge clk_i);
		fwd.capture_clk <= 1;
		repeat (4) @(posedge clk_i);
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk(bp_oe, 0);
		chk(card_oe, 0);
		wb(0, rbt_pkg::OFS_STATUS, 0);
		chk(q, 32'h0000_0000);
		$display("reset test done");
	endtask

	task automatic t_transp;
		fwd <= 4'b0010;
		card_d <= 18'h2_A5C3;
		settle;
		chk(bp_w, 18'h2_A5C3);
		chk(bp_oe, 18'h1_5A3C);
		chk(bp_o, 0);
		fwd.clk_en_n <= 1;
		card_d <= 18'h1_5A3C;
		settle;
		chk(bp_w, 18'h1_5A3C);
		fwd.drive_en_n <= 1;
		settle;
		chk(bp_oe, 0);
		$display("transparent test done");
	endtask

	task automatic t_clocked;
		fwd <= 4'b0000;
		@(posedge clk_i);
		cap(18'h0_F0F1);
		settle;
		chk(bp_w, 18'h0_F0F1);
		card_d <= 18'h3_0F0E;
		settle;
		chk(bp_w, 18'h0_F0F1);
		wb(0, rbt_pkg::OFS_FWD_HELD, 0);
		chk(q, 32'h0000_F0F1);
		fwd.clk_en_n <= 1;
		cap(18'h1_2345);
		settle;
		chk(bp_w, 18'h0_F0F1);
		$display("clocked test done");
	endtask

	task automatic t_reverse;
		// forward drive would still pull the shared wire low
		fwd.drive_en_n <= 1;
		settle;
		rev <= 4'b0010;
		bp_d <= 18'h2_5A96;
		settle;
		chk(card_oe, 18'h3_FFFF);
		chk(card_w, 18'h2_5A96);
		rev.latch_open <= 0;
		bp_d <= 18'h1_C3A5;
		repeat (4) @(posedge clk_i);
		rev.capture_clk <= 1;
		repeat (4) @(posedge clk_i);
		bp_d <= 18'h3_FFFF;
		settle;
		chk(card_o, 18'h1_C3A5);
		wb(0, rbt_pkg::OFS_REV_HELD, 0);
		chk(q, 32'h0001_C3A5);
		rev.drive_en_n <= 1;
		settle;
		chk(card_oe, 0);
		$display("reverse test done");
	endtask

	// nine captures into an eight word log: the last is refused
	task automatic t_log;
		fwd <= 4'b0000;
		wb(1, rbt_pkg::OFS_CTRL, 32'h0000_0001);
		for (int i = 0; i < 9; i++)
			cap(18'h1_5000 + 18'(i));
		settle;
		wb(0, rbt_pkg::OFS_STATUS, 0);
		chk(q, 32'h0000_080D);
		wb(0, rbt_pkg::OFS_FWD_HELD, 0);
		chk(q, 32'h0001_5007);
		for (int i = 0; i < 8; i++) begin
			wb(0, rbt_pkg::OFS_LOG, 0);
			chk(q, 32'h0001_5000 + 32'(i));
		end
		wb(0, rbt_pkg::OFS_LOG, 0);
		chk(q, 32'h0000_0000);
		wb(1, 8'h40, 32'hFFFF_FFFF);
		wb(0, 8'h40, 0);
		chk(q, 32'h0000_0000);
		$display("log test done");
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		t_reset;
		t_transp;
		t_clocked;
		t_reverse;
		t_log;
		final_report;
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		final_report;
	end
endmodule // registered_bus_transceiver_test
